// ==== jtid_tap_decode.sv ====
// What this block does
// - Sample TDI/TMS on TCK rise, TDO on fall.
// - EXTEST puts chain cells in test mode.
// - EXTEST capture takes system inputs and outputs.
// - EXTEST drives shifted data out only at Update-DR.
// - Chain-select instruction routes select register.
// - Chain-select capture loads pattern 0b10000.
// - Update-DR latches chain number until next select.
// - TAP reset selects chain three.
// - Scan path select register is five bits.
// - INTEST puts chain cells in test mode.
// - INTEST capture takes core and system values.
// - IDCODE routes 32-bit identification register.
// - Identification register loads from tie-off bus.
// - IDCODE keeps scan cells in normal mode.
// - IDCODE captures, shifts, ignores Update-DR.
// - BYPASS routes one-bit bypass register.
// - BYPASS keeps cells normal, pins unaffected.
// - BYPASS capture loads zero.
// - BYPASS delays TDI one TCK, first zero.
// - Update-DR leaves bypass register unchanged.
// - Unassigned instruction codes act as BYPASS.
// - Four-bit IR without parity, captures 0b0001.
// - Shifted IR becomes current only at Update-IR.
// - TAP reset selects IDCODE and exits debug.
// - Restart acts as BYPASS, resumes at idle.
`include "jtid_defs.svh"
module jtid_tap_decode (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic TCK,
    input wire logic TMS,
    input wire logic TDI,
    input wire logic TRST_N,
    input wire logic [`JTID_ID_W-1:0] ID_CODE_TIE_INPUT,
    input wire logic CHAIN_TDO,
    output logic TDO,
    output logic TDO_EN,
    output logic [`JTID_SEL_W-1:0] CHAIN_SEL,
    output logic CHAIN_CAPTURE,
    output logic CHAIN_SHIFT,
    output logic CHAIN_UPDATE,
    output logic CHAIN_TDI,
    output logic CELL_TEST_MODE,
    output logic EXTEST_ACTIVE,
    output logic INTEST_ACTIVE,
    output logic SAMPLE_ACTIVE,
    output logic DEBUG_EXIT,
    output logic RESTART_REQ
);
    logic [`JTID_SYNC_W-1:0] pins_s;
    logic tck_s, tms_s, tdi_s, tap_rst;
    logic tck_d_r;
    logic tck_rise, tck_fall;

    // TRST_N idles high, so the synchroniser resets it to the inactive level.
    jtid_sync #(.W(`JTID_SYNC_W)) u_sync (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .d({TRST_N, TDI, TMS, TCK}),
        .rst_val({1'b1, {(`JTID_SYNC_W-1){1'b0}}}),
        .q(pins_s)
    );

    assign tck_s = pins_s[0];
    assign tms_s = pins_s[1];
    assign tdi_s = pins_s[2];
    assign tap_rst = ~pins_s[3];
    assign tck_rise = tck_s & ~tck_d_r;
    assign tck_fall = ~tck_s & tck_d_r;

    jtid_pkg::jtid_tap_t tap_r, tap_nxt;
    jtid_pkg::jtid_dr_t dr_sel;
    logic [`JTID_IR_W-1:0] ir_r, ir_nxt, ir_sh_r, ir_sh_nxt;
    logic [`JTID_ID_W-1:0] id_r, id_nxt;
    logic [`JTID_SEL_W-1:0] sel_sh_r, sel_sh_nxt, chain_sel_nxt;
    logic byp_r, byp_nxt;
    logic tdo_nxt, tdo_en_nxt;
    logic cap_nxt, shf_nxt, upd_nxt, ctdi_nxt;
    logic test_nxt, ext_nxt, int_nxt, smp_nxt, dbg_nxt, rst_req_nxt;

    // Unassigned codes, restart included, fall through to the bypass path.
    always_comb begin
        case (ir_r)
            `JTID_IR_EXTEST: dr_sel = jtid_pkg::DR_CHAIN;
            `JTID_IR_INTEST: dr_sel = jtid_pkg::DR_CHAIN;
            `JTID_IR_SAMPLE: dr_sel = jtid_pkg::DR_CHAIN;
            `JTID_IR_SCAN_SEL: dr_sel = jtid_pkg::DR_SEL;
            `JTID_IR_IDCODE: dr_sel = jtid_pkg::DR_ID;
            default: dr_sel = jtid_pkg::DR_BYP;
        endcase
    end

    always_comb begin
        tap_nxt = tap_r;
        ir_nxt = ir_r;
        ir_sh_nxt = ir_sh_r;
        id_nxt = id_r;
        sel_sh_nxt = sel_sh_r;
        chain_sel_nxt = CHAIN_SEL;
        byp_nxt = byp_r;
        tdo_nxt = TDO;
        tdo_en_nxt = TDO_EN;
        cap_nxt = 1'b0;
        shf_nxt = 1'b0;
        upd_nxt = 1'b0;
        ctdi_nxt = CHAIN_TDI;
        rst_req_nxt = 1'b0;
        if (tck_rise) begin
            case (tap_r)
                jtid_pkg::TS_TLR: tap_nxt = tms_s ? jtid_pkg::TS_TLR
                                                  : jtid_pkg::TS_RTI;
                jtid_pkg::TS_RTI: tap_nxt = tms_s ? jtid_pkg::TS_SELDR
                                                  : jtid_pkg::TS_RTI;
                jtid_pkg::TS_SELDR: tap_nxt = tms_s ? jtid_pkg::TS_SELIR
                                                    : jtid_pkg::TS_CAPDR;
                jtid_pkg::TS_CAPDR: tap_nxt = tms_s ? jtid_pkg::TS_EX1DR
                                                    : jtid_pkg::TS_SHDR;
                jtid_pkg::TS_SHDR: tap_nxt = tms_s ? jtid_pkg::TS_EX1DR
                                                   : jtid_pkg::TS_SHDR;
                jtid_pkg::TS_EX1DR: tap_nxt = tms_s ? jtid_pkg::TS_UPDR
                                                    : jtid_pkg::TS_PDR;
                jtid_pkg::TS_PDR: tap_nxt = tms_s ? jtid_pkg::TS_EX2DR
                                                  : jtid_pkg::TS_PDR;
                jtid_pkg::TS_EX2DR: tap_nxt = tms_s ? jtid_pkg::TS_UPDR
                                                    : jtid_pkg::TS_SHDR;
                jtid_pkg::TS_UPDR: tap_nxt = tms_s ? jtid_pkg::TS_SELDR
                                                   : jtid_pkg::TS_RTI;
                jtid_pkg::TS_SELIR: tap_nxt = tms_s ? jtid_pkg::TS_TLR
                                                    : jtid_pkg::TS_CAPIR;
                jtid_pkg::TS_CAPIR: tap_nxt = tms_s ? jtid_pkg::TS_EX1IR
                                                    : jtid_pkg::TS_SHIR;
                jtid_pkg::TS_SHIR: tap_nxt = tms_s ? jtid_pkg::TS_EX1IR
                                                   : jtid_pkg::TS_SHIR;
                jtid_pkg::TS_EX1IR: tap_nxt = tms_s ? jtid_pkg::TS_UPIR
                                                    : jtid_pkg::TS_PIR;
                jtid_pkg::TS_PIR: tap_nxt = tms_s ? jtid_pkg::TS_EX2IR
                                                  : jtid_pkg::TS_PIR;
                jtid_pkg::TS_EX2IR: tap_nxt = tms_s ? jtid_pkg::TS_UPIR
                                                    : jtid_pkg::TS_SHIR;
                jtid_pkg::TS_UPIR: tap_nxt = tms_s ? jtid_pkg::TS_SELDR
                                                   : jtid_pkg::TS_RTI;
                default: tap_nxt = jtid_pkg::TS_TLR;
            endcase
            case (tap_r)
                jtid_pkg::TS_CAPIR: ir_sh_nxt = `JTID_IR_CAPTURE;
                jtid_pkg::TS_SHIR: ir_sh_nxt = {tdi_s, ir_sh_r[3:1]};
                jtid_pkg::TS_UPIR: ir_nxt = ir_sh_r;
                jtid_pkg::TS_CAPDR: begin
                    case (dr_sel)
                        jtid_pkg::DR_BYP: byp_nxt = 1'b0;
                        jtid_pkg::DR_ID: id_nxt = ID_CODE_TIE_INPUT;
                        jtid_pkg::DR_SEL: sel_sh_nxt = `JTID_SEL_CAPTURE;
                        default: cap_nxt = 1'b1;
                    endcase
                end
                jtid_pkg::TS_SHDR: begin
                    case (dr_sel)
                        jtid_pkg::DR_BYP: byp_nxt = tdi_s;
                        jtid_pkg::DR_ID: id_nxt = {tdi_s, id_r[31:1]};
                        jtid_pkg::DR_SEL: sel_sh_nxt = {tdi_s, sel_sh_r[4:1]};
                        default: begin
                            shf_nxt = 1'b1;
                            ctdi_nxt = tdi_s;
                        end
                    endcase
                end
                jtid_pkg::TS_UPDR: begin
                    // Bypass and identification registers hold here.
                    case (dr_sel)
                        jtid_pkg::DR_SEL: chain_sel_nxt = sel_sh_r;
                        jtid_pkg::DR_CHAIN: upd_nxt = 1'b1;
                        default: upd_nxt = 1'b0;
                    endcase
                end
                default: upd_nxt = 1'b0;
            endcase
            if (tap_nxt == jtid_pkg::TS_RTI && tap_r != jtid_pkg::TS_RTI
                && ir_nxt == `JTID_IR_RESTART) begin
                rst_req_nxt = 1'b1;
            end
        end
        if (tck_fall) begin
            tdo_en_nxt = (tap_r == jtid_pkg::TS_SHDR)
                         || (tap_r == jtid_pkg::TS_SHIR);
            if (tap_r == jtid_pkg::TS_SHIR) begin
                tdo_nxt = ir_sh_r[0];
            end else begin
                case (dr_sel)
                    jtid_pkg::DR_BYP: tdo_nxt = byp_r;
                    jtid_pkg::DR_ID: tdo_nxt = id_r[0];
                    jtid_pkg::DR_SEL: tdo_nxt = sel_sh_r[0];
                    default: tdo_nxt = CHAIN_TDO;
                endcase
            end
        end
        // Test-Logic-Reset holds the decode at its power-up values.
        if (tap_nxt == jtid_pkg::TS_TLR) begin
            ir_nxt = `JTID_IR_IDCODE;
            chain_sel_nxt = `JTID_SEL_RESET;
        end
        test_nxt = (ir_nxt == `JTID_IR_EXTEST)
                   || (ir_nxt == `JTID_IR_INTEST);
        ext_nxt = ir_nxt == `JTID_IR_EXTEST;
        int_nxt = ir_nxt == `JTID_IR_INTEST;
        smp_nxt = ir_nxt == `JTID_IR_SAMPLE;
        dbg_nxt = tap_nxt == jtid_pkg::TS_TLR;
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST || tap_rst) begin
            tap_r <= jtid_pkg::TS_TLR;
            ir_r <= `JTID_IR_IDCODE;
            ir_sh_r <= `JTID_IR_CAPTURE;
            id_r <= '0;
            sel_sh_r <= '0;
            CHAIN_SEL <= `JTID_SEL_RESET;
            byp_r <= 1'b0;
            TDO <= 1'b0;
            TDO_EN <= 1'b0;
            CHAIN_CAPTURE <= 1'b0;
            CHAIN_SHIFT <= 1'b0;
            CHAIN_UPDATE <= 1'b0;
            CHAIN_TDI <= 1'b0;
            CELL_TEST_MODE <= 1'b0;
            EXTEST_ACTIVE <= 1'b0;
            INTEST_ACTIVE <= 1'b0;
            SAMPLE_ACTIVE <= 1'b0;
            DEBUG_EXIT <= 1'b1;
            RESTART_REQ <= 1'b0;
            tck_d_r <= 1'b0;
        end else begin
            tap_r <= tap_nxt;
            ir_r <= ir_nxt;
            ir_sh_r <= ir_sh_nxt;
            id_r <= id_nxt;
            sel_sh_r <= sel_sh_nxt;
            CHAIN_SEL <= chain_sel_nxt;
            byp_r <= byp_nxt;
            TDO <= tdo_nxt;
            TDO_EN <= tdo_en_nxt;
            CHAIN_CAPTURE <= cap_nxt;
            CHAIN_SHIFT <= shf_nxt;
            CHAIN_UPDATE <= upd_nxt;
            CHAIN_TDI <= ctdi_nxt;
            CELL_TEST_MODE <= test_nxt;
            EXTEST_ACTIVE <= ext_nxt;
            INTEST_ACTIVE <= int_nxt;
            SAMPLE_ACTIVE <= smp_nxt;
            DEBUG_EXIT <= dbg_nxt;
            RESTART_REQ <= rst_req_nxt;
            tck_d_r <= tck_s;
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST || tap_rst);

    sequence s_cap_dr;
        tck_rise && tap_r == jtid_pkg::TS_CAPDR;
    endsequence

    sequence s_upd_dr;
        tck_rise && tap_r == jtid_pkg::TS_UPDR;
    endsequence

    AST_TDO_ON_FALL: assert property (
        $changed(TDO) |-> $past(tck_fall))
        else $error("TDO moved without a falling TCK edge.");
    AST_IR_CAPTURE: assert property (
        tck_rise && tap_r == jtid_pkg::TS_CAPIR |=> ir_sh_r == 4'h1)
        else $error("Instruction capture pattern wrong.");
    AST_IR_UPDATE_ONLY: assert property (
        $changed(ir_r) |-> $past(tap_nxt) == jtid_pkg::TS_TLR
            || $past(tap_r) == jtid_pkg::TS_UPIR)
        else $error("Instruction changed outside Update-IR.");
    AST_SEL_CAPTURE: assert property (
        s_cap_dr ##0 dr_sel == jtid_pkg::DR_SEL |=> sel_sh_r == 5'h10)
        else $error("Select register capture pattern wrong.");
    AST_BYP_CAPTURE: assert property (
        s_cap_dr ##0 dr_sel == jtid_pkg::DR_BYP |=> !byp_r)
        else $error("Bypass register did not capture zero.");
    AST_ID_CAPTURE: assert property (
        s_cap_dr ##0 dr_sel == jtid_pkg::DR_ID |=> id_r == ID_CODE_TIE_INPUT)
        else $error("Identification register capture wrong.");
    AST_SEL_UPDATE: assert property (
        s_upd_dr ##0 dr_sel == jtid_pkg::DR_SEL
            |=> CHAIN_SEL == $past(sel_sh_r) ##1 CHAIN_SEL == $past(CHAIN_SEL))
        else $error("Chain select not taken at Update-DR.");
    AST_BYP_HOLD: assert property (
        s_upd_dr |=> byp_r == $past(byp_r))
        else $error("Bypass register disturbed by Update-DR.");
    AST_TEST_MODE: assert property (
        ##1 CELL_TEST_MODE == (ir_r == 4'h0 || ir_r == 4'hc))
        else $error("Cell test mode disagrees with instruction.");
    AST_UNUSED_BYPASS: assert property (
        !(ir_r inside {4'h0, 4'h2, 4'h3, 4'hc, 4'he}) |-> dr_sel == jtid_pkg::DR_BYP)
        else $error("Unassigned code did not select bypass.");
    AST_TLR_RESET: assert property (
        tap_r == jtid_pkg::TS_TLR |-> CHAIN_SEL == 5'h03 && ir_r == 4'he)
        else $error("Test-Logic-Reset did not restore defaults.");
endmodule

// ==== jtid_defs.svh ====
`ifndef JTID_DEFS_SVH
`define JTID_DEFS_SVH

`define JTID_IR_W 4
`define JTID_SEL_W 5
`define JTID_ID_W 32
`define JTID_SYNC_W 4

`define JTID_IR_EXTEST 4'h0
`define JTID_IR_SCAN_SEL 4'h2
`define JTID_IR_SAMPLE 4'h3
`define JTID_IR_RESTART 4'h4
`define JTID_IR_INTEST 4'hc
`define JTID_IR_IDCODE 4'he
`define JTID_IR_BYPASS 4'hf

`define JTID_IR_CAPTURE 4'h1
`define JTID_SEL_CAPTURE 5'h10
`define JTID_SEL_RESET 5'h03

`endif

// ==== jtid_pkg.sv ====
package jtid_pkg;

    typedef enum logic [15:0] {
        TS_TLR = 16'h0001,
        TS_RTI = 16'h0002,
        TS_SELDR = 16'h0004,
        TS_CAPDR = 16'h0008,
        TS_SHDR = 16'h0010,
        TS_EX1DR = 16'h0020,
        TS_PDR = 16'h0040,
        TS_EX2DR = 16'h0080,
        TS_UPDR = 16'h0100,
        TS_SELIR = 16'h0200,
        TS_CAPIR = 16'h0400,
        TS_SHIR = 16'h0800,
        TS_EX1IR = 16'h1000,
        TS_PIR = 16'h2000,
        TS_EX2IR = 16'h4000,
        TS_UPIR = 16'h8000
    } jtid_tap_t;

    typedef enum logic [3:0] {
        DR_BYP = 4'h1,
        DR_ID = 4'h2,
        DR_SEL = 4'h4,
        DR_CHAIN = 4'h8
    } jtid_dr_t;

endpackage

// ==== jtid_sync.sv ====
module jtid_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // The first stage feeds the second stage only.
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= rst_val;
            q <= rst_val;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

// ==== jtid_probe_model.sv ====
module jtid_probe_model (
    input wire logic clk,
    input wire logic tdo,
    output logic tck,
    output logic tms,
    output logic tdi
);
    timeunit 1ns;
    timeprecision 100ps;

    // Half of the 32 ns link period, counted in system clock cycles.
    localparam int HALF = 4;

    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end

    // Data changes with the fall; TDO is taken just before the next fall,
    // so it is the value that stood at the rise.
    task automatic tick(input logic m, input logic d, output logic q);
        tck = 1'b0;
        tms = m;
        tdi = d;
        repeat (HALF) @(negedge clk);
        tck = 1'b1;
        repeat (HALF) @(negedge clk);
        q = tdo;
    endtask

    // The clock stands low between frames and the stale data bit is turned
    // round, so nothing can lean on a value that is no longer meaningful.
    task automatic park();
        tck = 1'b0;
        tdi = ~tdi;
        repeat (HALF) @(negedge clk);
    endtask

    task automatic reset_tap();
        logic q;
        repeat (5) tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        park();
    endtask

    // Runs from Run-Test/Idle through one scan back to Run-Test/Idle.
    task automatic scan(input logic ir, input int n, input logic [63:0] din,
                        output logic [63:0] dout);
        logic q;
        dout = '0;
        tick(1'b1, 1'b0, q);
        if (ir) begin
            tick(1'b1, 1'b0, q);
        end
        tick(1'b0, 1'b0, q);
        tick(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], q);
            dout[i] = q;
        end
        tick(1'b1, 1'b0, q);
        tick(1'b0, 1'b0, q);
        park();
    endtask
endmodule

// ==== jtag_tap_instruction_decode_bench.sv ====
`include "jtid_defs.svh"
module jtag_tap_instruction_decode_bench;
    timeunit 1ns;
    timeprecision 100ps;

    // Arbitrary identification value, chosen only for this bench.
    localparam logic [31:0] ID_VAL = 32'h5a3c_0f01;

    logic clk_sys, sys_rst, trst_n, tck, tms, tdi, chain_tdo, tdo, tdo_en;
    logic [4:0] chain_sel;
    logic chain_capture, chain_shift, chain_update, chain_tdi;
    logic cell_test_mode, extest_active, intest_active, sample_active;
    logic debug_exit, restart_req;
    logic [7:0] chain_r = 8'h00;
    int upd_cnt = 0;
    int rst_req_cnt = 0;
    logic [63:0] dout;
    int n_mismatch = 0;
    int num_checks = 0;

    jtid_tap_decode i_jtid_tap_decode (
        .CLK_SYS(clk_sys), .SYS_RST(sys_rst), .TCK(tck), .TMS(tms),
        .TDI(tdi), .TRST_N(trst_n), .ID_CODE_TIE_INPUT(ID_VAL),
        .CHAIN_TDO(chain_tdo), .TDO(tdo), .TDO_EN(tdo_en),
        .CHAIN_SEL(chain_sel), .CHAIN_CAPTURE(chain_capture),
        .CHAIN_SHIFT(chain_shift), .CHAIN_UPDATE(chain_update),
        .CHAIN_TDI(chain_tdi), .CELL_TEST_MODE(cell_test_mode),
        .EXTEST_ACTIVE(extest_active), .INTEST_ACTIVE(intest_active),
        .SAMPLE_ACTIVE(sample_active), .DEBUG_EXIT(debug_exit),
        .RESTART_REQ(restart_req)
    );

    jtid_probe_model i_jtid_probe_model (
        .clk(clk_sys), .tdo(tdo), .tck(tck), .tms(tms), .tdi(tdi)
    );

    // Eight-cell stand-in for the selected chain; it reacts at the falling
    // edge so the next bit stands well before the link fall is seen.
    always @(negedge clk_sys) begin
        if (chain_capture) begin
            chain_r <= 8'ha5;
        end else if (chain_shift) begin
            chain_r <= {chain_tdi, chain_r[7:1]};
        end
        if (chain_update) begin
            upd_cnt <= upd_cnt + 1;
        end
        if (restart_req) begin
            rst_req_cnt <= rst_req_cnt + 1;
        end
    end
    assign chain_tdo = chain_r[0];

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                       input string msg);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    task automatic set_ir(input logic [3:0] code);
        i_jtid_probe_model.scan(1'b1, 4, {60'h0, code}, dout);
        chk(dout[3:0], `JTID_IR_CAPTURE, "ir capture pattern");
    endtask

    task automatic t_reset_id();
        chk(chain_sel, `JTID_SEL_RESET, "default chain");
        chk(debug_exit, 1'b1, "debug exit in reset");
        i_jtid_probe_model.reset_tap();
        chk(debug_exit, 1'b0, "debug exit left after reset");
        chk(cell_test_mode, 1'b0, "cells normal under id");
        i_jtid_probe_model.scan(1'b0, 32, '1, dout);
        chk(dout[31:0], ID_VAL, "identification shift");
        chk(tdo_en, 1'b0, "tdo released after scan");
    endtask

    task automatic t_bypass_like();
        logic [3:0] codes [5] = '{`JTID_IR_BYPASS, `JTID_IR_RESTART,
                                  4'h5, 4'h9, 4'hb};
        int c0;
        for (int k = 0; k < 5; k++) begin
            c0 = rst_req_cnt;
            set_ir(codes[k]);
            chk(rst_req_cnt - c0, codes[k] == `JTID_IR_RESTART,
                "restart request");
            i_jtid_probe_model.scan(1'b0, 8, 64'h6b, dout);
            chk(dout[7:0], 8'hd6, "bypass delay");
            chk(cell_test_mode, 1'b0, "cells normal in bypass");
        end
    endtask

    task automatic t_scan_sel();
        set_ir(`JTID_IR_SCAN_SEL);
        i_jtid_probe_model.scan(1'b0, 6, 64'h1f, dout);
        chk(dout[5:0], 6'h30, "select capture and width");
        chk(chain_sel, 5'h0f, "chain updated");
        set_ir(`JTID_IR_BYPASS);
        chk(chain_sel, 5'h0f, "chain held");
    endtask

    task automatic t_chain();
        logic [3:0] codes [3] = '{`JTID_IR_EXTEST, `JTID_IR_INTEST,
                                  `JTID_IR_SAMPLE};
        logic [7:0] din;
        int c0;
        for (int k = 0; k < 3; k++) begin
            din = 8'h3c ^ {4'h0, codes[k]};
            set_ir(codes[k]);
            chk(cell_test_mode, k < 2, "cell test mode");
            chk({extest_active, intest_active, sample_active},
                3'b100 >> k, "mode flags");
            c0 = upd_cnt;
            i_jtid_probe_model.scan(1'b0, 8, {56'h0, din}, dout);
            chk(dout[7:0], 8'ha5, "chain capture out");
            chk(chain_r, din, "chain shifted in");
            chk(upd_cnt - c0, 1, "chain update pulse");
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        $display("[FAIL] %0t watchdog expired", $time);
        finish_test();
    end

    initial begin
        sys_rst = 1'b1;
        trst_n = 1'b1;
        repeat (8) @(negedge clk_sys);
        sys_rst = 1'b0;
        repeat (3) @(negedge clk_sys);
        t_reset_id();
        t_bypass_like();
        t_scan_sel();
        t_chain();
        trst_n = 1'b0;
        repeat (4) @(negedge clk_sys);
        trst_n = 1'b1;
        repeat (3) @(negedge clk_sys);
        t_reset_id();
        finish_test();
    end
endmodule
